//--- src/psq_pkg.sv
`default_nettype none
package psq_pkg;
  // program store limits
  localparam int PSQ_MAX_PHASE = 41;
  localparam logic [6:0] MAX_PH7 = 7'h29;
  localparam int LOOP_DEPTH = 3;
  localparam logic [1:0] LOOP_DEPTH2 = 2'h3;
  // pause timing: 0.1 s tick at 100 MHz
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 100_000_000;
  localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;
  localparam logic [3:0] TICK_LAST_SUB = 4'h9;
  // register map
  localparam logic [7:0] ADDR_PROG_LAST = 8'h28;
  localparam logic [7:0] ADDR_CTRL = 8'h40;
  localparam logic [7:0] ADDR_STAT = 8'h41;
  localparam int CTRL_ALARM_BIT = 0;
  localparam logic CTRL_ALARM_RST = 1'b0;
  // phase function codes
  typedef enum logic [3:0] {
    OP_PUMP = 4'h0,
    OP_STOP = 4'h1,
    OP_LOOP_BEGIN = 4'h2,
    OP_LOOP_FOREVER = 4'h3,
    OP_LOOP_COUNTED = 4'h4,
    OP_PAUSE = 4'h5,
    OP_JUMP_LOW = 4'h6,
    OP_TRAP_FALL = 4'h7,
    OP_TRAP_EITHER = 4'h8,
    OP_TRAP_CANCEL = 4'h9,
    OP_GOTO = 4'ha,
    OP_OUT_SET = 4'hb,
    OP_BEEP = 4'hc,
    OP_LABEL = 4'hd
  } psq_op_t;
  // one stored phase, low 12 bits of a bus word
  typedef struct packed {
    psq_op_t op;
    logic tenths;
    logic [6:0] arg;
  } psq_word_t;
  // one loop stack entry
  typedef struct packed {
    logic [5:0] target;
    logic [5:0] end_ph;
    logic [6:0] cnt;
    logic paired;
  } psq_loop_t;
  // sequencer states, gray along the usual path
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_EXEC = 3'h1,
    S_PUMP = 3'h3,
    S_PAUSE = 3'h2,
    S_WAIT = 3'h6
  } psq_state_t;
endpackage
`default_nettype wire

//--- src/psq_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - unpaired loop end pairs latest open start
// - paired loop end counts, returns to start
// - forever loop end never falls through
// - counted end exits after nn, unpairs
// - loop stack three layers deep
// - whole-second pause up to 99
// - tenths pause, countdown shows one
// - zero pause waits for start trigger
// - three start sources; other key stops a wait
// - buzzer on while waiting, alarms on
// - jump when program input low
// - event setup arms single-shot trap
// - falling edge fires trap
// - fire aborts, jumps, disarms
// - new arm overwrites old trap
// - either-edge trap variant
// - trap cancel disarms, no jump
// - output set drives level 0 or 1
// - past phase 41 acts as stop
// - stop ends; next start at phase 1
// - goto continues at given phase
module psq_sequencer #(
  parameter int TICK_CYC = psq_pkg::TICK_CYC_DEF
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // start and key sources
  input wire logic start_key_in,
  input wire logic other_key_in,
  input wire logic ext_trig_in,
  input wire logic serial_start_in,
  // logic-level lines
  input wire logic event_in,
  input wire logic prog_in_in,
  output logic prog_out_out,
  // pump engine handshake
  output logic pump_req_out,
  output logic pump_abort_out,
  input wire logic pump_done_in,
  // status
  output logic [5:0] phase_out,
  output logic running_out,
  output logic buzzer_out,
  output logic beep_out,
  output logic [6:0] countdown_out,
  output logic trap_armed_out
);
  import psq_pkg::*;

  // program store, phase n at index n-1
  psq_word_t prog [PSQ_MAX_PHASE];
  psq_state_t state; // sequencer state
  logic [5:0] phase; // current phase
  logic alarm_en; // control bit
  // loop stack
  psq_loop_t stk [LOOP_DEPTH];
  logic [1:0] sp; // entries in use
  // trap
  logic armed;
  logic either; // either-edge mode
  logic [6:0] trap_tgt;
  // pause timer
  logic [23:0] ctr; // cycles within a tick
  logic [3:0] sub; // ticks within a second
  logic [6:0] left; // units left
  logic tenths; // unit is one tick
  // synchronisers
  logic ev_s1, ev_s2, ev_s3;
  logic in_s1, in_s2;

  // decode of the current phase
  wire logic [5:0] idx = 6'(phase - 6'h01);
  wire psq_word_t cur_w = prog[idx];
  wire logic [6:0] seq7 = 7'({1'b0, phase} + 7'h01);
  wire logic run_st = state != S_IDLE;
  wire logic start_any = start_key_in | ext_trig_in | serial_start_in;
  wire logic is_loop_end = cur_w.op == OP_LOOP_FOREVER ||
                           cur_w.op == OP_LOOP_COUNTED;

  // edges seen only on the settled copies
  wire logic ev_fall = ev_s3 & ~ev_s2;
  wire logic ev_rise = ~ev_s3 & ev_s2;
  wire logic trap_fire = armed && run_st &&
                         (ev_fall || (either && ev_rise));
  wire logic exec_en = state == S_EXEC && !trap_fire;

  // loop pairing decode
  wire logic [1:0] sp_m1 = 2'(sp - 2'h1);
  wire psq_loop_t top_e = (sp == 2'h0) ? '0 : stk[sp_m1];
  wire logic top_hit = sp != 2'h0 && top_e.paired &&
                       top_e.end_ph == phase;
  wire logic pair_top = sp != 2'h0 && !top_e.paired;
  wire logic own_top = top_hit | pair_top;
  wire logic [6:0] cnt_now = top_hit ? top_e.cnt : cur_w.arg;
  wire logic [6:0] cnt_dec = 7'(cnt_now - 7'h01);
  wire logic loop_done = cur_w.op == OP_LOOP_COUNTED &&
                         cnt_now <= 7'h01;
  wire logic [6:0] loop_tgt = loop_done ? seq7 :
                   own_top ? {1'b0, top_e.target} : 7'h01;
  wire psq_loop_t new_e = '{
    target: own_top ? top_e.target : 6'h01,
    end_ph: phase, cnt: cnt_dec, paired: 1'b1};

  // pause timer decode
  wire logic tick = ctr == 24'(TICK_CYC - 1);
  wire logic last_sub = tenths || sub == TICK_LAST_SUB;
  wire logic pause_end = state == S_PAUSE && tick && last_sub &&
                         left == 7'h01;

  // branch target of the executing phase
  logic [6:0] exec_tgt;
  always_comb begin
    case (cur_w.op)
      OP_GOTO: exec_tgt = cur_w.arg;
      OP_JUMP_LOW: exec_tgt = in_s2 ? seq7 : cur_w.arg;
      OP_LOOP_FOREVER,
      OP_LOOP_COUNTED: exec_tgt = loop_tgt;
      default: exec_tgt = seq7;
    endcase
  end

  // one target path for every advance and branch; trap, stop and resets set phase directly
  wire logic [6:0] jump_tgt = state == S_EXEC ? exec_tgt : seq7;
  wire logic jump_ok = jump_tgt != 7'h00 && jump_tgt <= MAX_PH7;
  wire logic trap_ok = trap_tgt != 7'h00 && trap_tgt <= MAX_PH7;

  always_ff @(posedge clk_in) begin
    ev_s1 <= event_in;
    ev_s2 <= ev_s1;
    ev_s3 <= ev_s2;
    in_s1 <= prog_in_in;
    in_s2 <= in_s1;
  end

  // program store writes, no reset needed
  always_ff @(posedge clk_in) begin
    if (wr_in && addr_in <= ADDR_PROG_LAST) begin
      prog[addr_in[5:0]] <= psq_word_t'(wdata_in[11:0]);
    end
  end

  // status word for reads
  wire logic [15:0] stat_w = {3'h0, prog_out_out, phase, state,
                              sp, armed};
  wire logic [15:0] rd_mux =
    (addr_in <= ADDR_PROG_LAST) ? {4'h0, prog[addr_in[5:0]]} :
    (addr_in == ADDR_CTRL) ? {15'h0000, alarm_en} :
    (addr_in == ADDR_STAT) ? stat_w : 16'h0000;

  // control register and read answer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      alarm_en <= CTRL_ALARM_RST;
      rdata_out <= 16'h0000;
    end else begin
      // data stand only in the cycle after the strobe
      rdata_out <= rd_in ? rd_mux : 16'h0000;
      if (wr_in && addr_in == ADDR_CTRL) begin
        alarm_en <= wdata_in[CTRL_ALARM_BIT];
      end
    end
  end

  // loop stack upkeep
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sp <= 2'h0;
    end else if (state == S_IDLE && start_any) begin
      sp <= 2'h0;
    end else if (exec_en && cur_w.op == OP_LOOP_BEGIN) begin
      if (sp < LOOP_DEPTH2) begin
        stk[sp] <= '{seq7[5:0], 6'h00, 7'h00, 1'b0};
        sp <= 2'(sp + 2'h1);
      end
    end else if (exec_en && is_loop_end) begin
      if (loop_done) begin
        if (own_top) begin
          sp <= sp_m1;
        end
      end else if (own_top) begin
        stk[sp_m1] <= new_e;
      end else if (sp < LOOP_DEPTH2) begin
        stk[sp] <= new_e;
        sp <= 2'(sp + 2'h1);
      end
    end
  end

  // background event trap
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      armed <= 1'b0;
      either <= 1'b0;
      trap_tgt <= 7'h00;
    end else if (trap_fire) begin
      armed <= 1'b0;
    end else if (state == S_IDLE && start_any) begin
      armed <= 1'b0; // fresh program, no trap
    end else if (exec_en) begin
      case (cur_w.op)
        OP_TRAP_FALL, OP_TRAP_EITHER: begin
          armed <= 1'b1;
          either <= cur_w.op == OP_TRAP_EITHER;
          trap_tgt <= cur_w.arg;
        end
        OP_TRAP_CANCEL: armed <= 1'b0;
        default: armed <= armed;
      endcase
    end
  end

  // pause timer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctr <= 24'h000000;
      sub <= 4'h0;
      left <= 7'h00;
      tenths <= 1'b0;
    end else if (exec_en && cur_w.op == OP_PAUSE) begin
      ctr <= 24'h000000;
      sub <= 4'h0;
      left <= cur_w.arg;
      tenths <= cur_w.tenths;
    end else if (state == S_PAUSE) begin
      if (tick) begin
        ctr <= 24'h000000;
        // one tick per unit in tenths
        if (last_sub) begin
          sub <= 4'h0;
          left <= 7'(left - 7'h01);
        end else begin
          sub <= 4'(sub + 4'h1);
        end
      end else begin
        ctr <= 24'(ctr + 24'h000001);
      end
    end
  end

  // main sequencer
  always_ff @(posedge clk_in) begin
    pump_req_out <= 1'b0;
    pump_abort_out <= 1'b0;
    beep_out <= 1'b0;
    if (!rst_n_in) begin
      state <= S_IDLE;
      phase <= 6'h01;
      prog_out_out <= 1'b0;
    end else if (trap_fire) begin
      pump_abort_out <= state == S_PUMP;
      phase <= trap_ok ? trap_tgt[5:0] : 6'h01;
      state <= trap_ok ? S_EXEC : S_IDLE;
    end else begin
      case (state)
        S_IDLE: begin
          // program always starts at phase 1
          phase <= 6'h01;
          if (start_any) begin
            state <= S_EXEC;
          end
        end
        S_EXEC: begin
          case (cur_w.op)
            OP_PUMP: begin
              pump_req_out <= 1'b1;
              state <= S_PUMP;
            end
            OP_STOP: begin
              state <= S_IDLE;
              phase <= 6'h01;
            end
            OP_PAUSE: begin
              state <= cur_w.arg == 7'h00 ? S_WAIT : S_PAUSE;
            end
            default: begin
              phase <= jump_ok ? jump_tgt[5:0] : 6'h01;
              state <= jump_ok ? S_EXEC : S_IDLE;
              if (cur_w.op == OP_OUT_SET) begin
                prog_out_out <= cur_w.arg[0];
              end
              if (cur_w.op == OP_BEEP) begin
                beep_out <= 1'b1;
              end
            end
          endcase
        end
        S_PUMP: begin
          if (start_key_in) begin
            // key stops a running program
            pump_abort_out <= 1'b1;
            state <= S_IDLE;
          end else if (pump_done_in) begin
            phase <= jump_ok ? jump_tgt[5:0] : 6'h01;
            state <= jump_ok ? S_EXEC : S_IDLE;
          end
        end
        S_PAUSE: begin
          if (start_key_in) begin
            state <= S_IDLE;
          end else if (pause_end) begin
            phase <= jump_ok ? jump_tgt[5:0] : 6'h01;
            state <= jump_ok ? S_EXEC : S_IDLE;
          end
        end
        S_WAIT: begin
          // any source resumes; other key resets
          if (start_any) begin
            phase <= jump_ok ? jump_tgt[5:0] : 6'h01;
            state <= jump_ok ? S_EXEC : S_IDLE;
          end else if (other_key_in) begin
            state <= S_IDLE;
            phase <= 6'h01;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // registered status outputs, one cycle behind state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      running_out <= 1'b0;
      buzzer_out <= 1'b0;
      countdown_out <= 7'h00;
    end else begin
      running_out <= run_st;
      buzzer_out <= alarm_en && state == S_WAIT;
      countdown_out <= state != S_PAUSE ? 7'h00 :
                       tenths ? 7'h01 : left;
    end
  end

  assign phase_out = phase;
  assign trap_armed_out = armed;

  // trap jumps to its stored target
  trap_jump_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    trap_fire && trap_ok |=> state == S_EXEC &&
      phase == $past(trap_tgt[5:0]) && !armed)
    else $error("trap did not jump");

  // falling edge while armed must fire
  fall_fire_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    $fell(ev_s2) && armed && run_st |-> trap_fire)
    else $error("falling edge missed");

  // rising edge fires only in either mode
  rise_mode_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    $rose(ev_s2) && armed && !either |-> !trap_fire)
    else $error("rising edge fired fall trap");

  // output phase sets level
  out_set_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    exec_en && cur_w.op == OP_OUT_SET |=>
      prog_out_out == $past(cur_w.arg[0]))
    else $error("output level wrong");

  // buzzer follows the wait
  wait_buzz_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    state == S_WAIT && alarm_en ##1 state == S_WAIT
      |-> buzzer_out)
    else $error("buzzer silent in wait");

  // input low takes the branch
  jump_low_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    exec_en && cur_w.op == OP_JUMP_LOW && !in_s2 && jump_ok
      |=> phase == $past(cur_w.arg[5:0]))
    else $error("conditional jump wrong");

  // last phase falls off into idle
  past_max_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    exec_en && phase == 6'h29 && cur_w.op == OP_LABEL
      |=> state == S_IDLE ##1 !running_out)
    else $error("no stop past last phase");

  // forever loop never falls through
  forever_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    exec_en && cur_w.op == OP_LOOP_FOREVER |=>
      phase != 6'($past(phase) + 6'h01) || $past(own_top) == 1'b0
      && $past(phase) == 6'h00)
    else $error("forever loop fell through");

  // stack never exceeds three
  depth_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    sp <= LOOP_DEPTH2)
    else $error("loop stack overflow");

  // zero pause resumes at next phase
  wait_start_a: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    state == S_WAIT && start_any && !trap_fire && jump_ok
      |=> state == S_EXEC && phase == 6'($past(phase) + 6'h01))
    else $error("wait did not resume");
endmodule // psq_sequencer
`default_nettype wire

//--- sim/psq_far_side.sv
`timescale 1ns/100ps
`default_nettype none
// keypad, trigger lines and pump engine beside the sequencer
module psq_far_side (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // pump engine handshake
  input wire logic pump_req_in,
  input wire logic pump_abort_in,
  output logic pump_done_out,
  // start sources and keypad
  output logic start_key_out,
  output logic ext_trig_out,
  output logic serial_start_out,
  output logic other_key_out,
  // logic-level lines, idle high
  output logic event_out,
  output logic prog_in_out
);
  int dly; // pump op length in cycles
  int left; // cycles left in the op
  int abort_cnt; // aborts seen
  logic busy; // op in progress
  // quiet lines at time zero
  initial begin
    dly = 2;
    {pump_done_out, start_key_out, ext_trig_out} = 3'h0;
    {serial_start_out, other_key_out} = 2'h0;
    {event_out, prog_in_out} = 2'h3;
  end
  // pump op ends dly+1 cycles after the request unless aborted first
  always @(posedge clk_in) begin
    pump_done_out <= 1'b0;
    if (!rst_n_in) begin
      busy <= 1'b0;
      abort_cnt <= 0;
    end else if (pump_abort_in) begin
      busy <= 1'b0;
      abort_cnt <= abort_cnt + 1;
    end else if (pump_req_in) begin
      busy <= 1'b1;
      left <= dly;
    end else if (busy && left == 0) begin
      busy <= 1'b0;
      pump_done_out <= 1'b1;
    end else if (busy) begin
      left <= left - 1;
    end
  end
  // one-cycle key press: 0 start, 1 trigger, 2 serial, 3 other
  task automatic press(input int k);
    @(posedge clk_in);
    case (k)
      0: start_key_out <= 1'b1;
      1: ext_trig_out <= 1'b1;
      2: serial_start_out <= 1'b1;
      default: other_key_out <= 1'b1;
    endcase
    @(posedge clk_in);
    {start_key_out, ext_trig_out, serial_start_out, other_key_out} <= 4'h0;
  endtask
  // move the event and program-input levels
  task automatic set_line(input logic ev, input logic pin);
    @(posedge clk_in);
    event_out <= ev;
    prog_in_out <= pin;
  endtask
  // slow or prompt pump engine
  task automatic set_delay(input int d);
    dly = d;
  endtask
endmodule // psq_far_side
`default_nettype wire

//--- sim/pump_program_flow_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pump_program_flow_sequencer_tb_top;
  import psq_pkg::*;
  logic clk_in = 1'b0; // 100 MHz
  logic rst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic start_key_in, other_key_in, ext_trig_in, serial_start_in;
  logic event_in, prog_in_in, prog_out_out, pump_req_out;
  logic pump_abort_out, pump_done_in, running_out, buzzer_out;
  logic beep_out, trap_armed_out;
  logic [5:0] phase_out;
  logic [6:0] countdown_out;
  int err_total, n_tests, cyc; // tallies
  logic [15:0] rq[$]; // expected read data
  logic [5:0] pq[$]; // expected phase order
  logic [5:0] last_ph = 6'h01; // last phase seen
  logic rd_d = 1'b0; // read strobe one cycle back
  logic [15:0] pg[1:41]; // program image
  logic [31:0] seed = 32'h8f89979c;

  always #5 clk_in = ~clk_in;

  // short tick so pauses stay brief
  psq_sequencer #(.TICK_CYC(5)) u_psq_sequencer (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .start_key_in(start_key_in), .other_key_in(other_key_in),
    .ext_trig_in(ext_trig_in), .serial_start_in(serial_start_in),
    .event_in(event_in), .prog_in_in(prog_in_in),
    .prog_out_out(prog_out_out), .pump_req_out(pump_req_out),
    .pump_abort_out(pump_abort_out), .pump_done_in(pump_done_in),
    .phase_out(phase_out), .running_out(running_out),
    .buzzer_out(buzzer_out), .beep_out(beep_out),
    .countdown_out(countdown_out), .trap_armed_out(trap_armed_out));
  psq_far_side u_psq_far_side (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .pump_req_in(pump_req_out), .pump_abort_in(pump_abort_out),
    .pump_done_out(pump_done_in), .start_key_out(start_key_in),
    .ext_trig_out(ext_trig_in), .serial_start_out(serial_start_in),
    .other_key_out(other_key_in), .event_out(event_in),
    .prog_in_out(prog_in_in));

  // one comparison
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // a program word
  function automatic logic [15:0] wd(psq_op_t op, logic t, logic [6:0] a);
    psq_word_t w;
    w = '{op: op, tenths: t, arg: a};
    return {4'h0, w};
  endfunction
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // register bus cycles; read data noted for the watcher
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    rq.push_back(exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask
  // write the image, then blank it to labels
  task automatic load();
    for (int i = 1; i <= 41; i++) begin
      wr(8'(i - 1), pg[i]);
      pg[i] = wd(OP_LABEL, 1'b0, 7'h00);
    end
  endtask
  task automatic push_seq(input int s[$]);
    foreach (s[i]) pq.push_back(6'(s[i]));
  endtask
  task automatic wait_ph(input logic [5:0] p);
    while (phase_out !== p) @(negedge clk_in);
  endtask
  task automatic wait_idle();
    while (running_out !== 1'b0) @(negedge clk_in);
  endtask
  // length of a pause phase and its countdown
  task automatic run_len(input logic [5:0] p, input int lo, input int hi,
                         input logic [6:0] c1, input logic [6:0] c2);
    int n;
    n = 0;
    wait_ph(p);
    while (phase_out === p) begin
      if (n == 4) check("countdown", 16'(countdown_out), 16'(c1));
      if (n == 60) check("countdown", 16'(countdown_out), 16'(c2));
      @(negedge clk_in);
      n++;
    end
    check("pause length", 16'(n >= lo && n <= hi), 16'h0001);
  endtask

  // watcher: read data one cycle after strobe, phase order
  always @(posedge clk_in) rd_d <= rd_in;
  always @(negedge clk_in) begin
    if (rd_d && rq.size() > 0) check("rdata", rdata_out, rq.pop_front());
    if (rst_n_in && phase_out !== last_ph) begin
      last_ph = phase_out;
      if (pq.size() > 0) begin
        check("phase", 16'(phase_out), 16'(pq.pop_front()));
      end else begin
        check("phase", 16'(phase_out), 16'hffff);
      end
    end
  end
  // hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    foreach (pg[i]) pg[i] = wd(OP_LABEL, 1'b0, 7'h00);
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // registers: status, random word, control, refused writes
    rd(ADDR_STAT, 16'h0040);
    seed = lfsr(seed);
    wr(ADDR_PROG_LAST, seed[15:0]);
    rd(ADDR_PROG_LAST, {4'h0, seed[11:0]});
    wr(ADDR_CTRL, 16'h0001);
    wr(ADDR_STAT, 16'hffff);
    rd(ADDR_CTRL, 16'h0001);
    rd(ADDR_STAT, 16'h0040);
    rd(8'h50, 16'h0000);
    $display("test registers done");
    // nested counted loops, pauses, wait, output level
    pg[1] = wd(OP_OUT_SET, 1'b0, 7'h01);
    pg[2] = wd(OP_LOOP_BEGIN, 1'b0, 7'h00);
    pg[3] = wd(OP_LOOP_BEGIN, 1'b0, 7'h00);
    pg[4] = wd(OP_PUMP, 1'b0, 7'h00);
    pg[5] = wd(OP_LOOP_COUNTED, 1'b0, 7'h02);
    pg[6] = wd(OP_LOOP_COUNTED, 1'b0, 7'h02);
    pg[7] = wd(OP_PAUSE, 1'b1, 7'h03);
    pg[8] = wd(OP_PAUSE, 1'b0, 7'h02);
    pg[9] = wd(OP_PAUSE, 1'b0, 7'h00);
    pg[10] = wd(OP_OUT_SET, 1'b0, 7'h00);
    pg[11] = wd(OP_STOP, 1'b0, 7'h00);
    load();
    seed = lfsr(seed);
    u_psq_far_side.set_delay(1 + int'(seed[2:0]));
    push_seq('{2, 3, 4, 5, 4, 5, 6, 3, 4, 5, 4, 5, 6, 7, 8, 9, 10, 11, 1});
    u_psq_far_side.press(0);
    wait_ph(6'd3);
    check("out high", 16'(prog_out_out), 16'h0001);
    run_len(6'd7, 15, 25, 7'h01, 7'h01);
    run_len(6'd8, 100, 110, 7'h02, 7'h01);
    wait_ph(6'd9);
    repeat (5) @(negedge clk_in);
    check("buzzer", 16'(buzzer_out), 16'h0001);
    u_psq_far_side.press(2);
    wait_idle();
    check("out low", 16'(prog_out_out), 16'h0000);
    $display("test loops and pauses done");
    // traps, conditional jumps, goto, end of store
    pg[1] = wd(OP_TRAP_FALL, 1'b0, 7'h05);
    pg[2] = wd(OP_PUMP, 1'b0, 7'h00);
    pg[5] = wd(OP_TRAP_EITHER, 1'b0, 7'h08);
    pg[6] = wd(OP_TRAP_EITHER, 1'b0, 7'h09);
    pg[7] = wd(OP_PUMP, 1'b0, 7'h00);
    pg[8] = wd(OP_PUMP, 1'b0, 7'h00);
    pg[9] = wd(OP_TRAP_FALL, 1'b0, 7'h03);
    pg[10] = wd(OP_TRAP_CANCEL, 1'b0, 7'h00);
    pg[11] = wd(OP_PUMP, 1'b0, 7'h00);
    pg[12] = wd(OP_JUMP_LOW, 1'b0, 7'h03);
    pg[13] = wd(OP_PUMP, 1'b0, 7'h00);
    pg[14] = wd(OP_JUMP_LOW, 1'b0, 7'h10);
    pg[15] = wd(OP_STOP, 1'b0, 7'h00);
    pg[16] = wd(OP_GOTO, 1'b0, 7'h29);
    load();
    u_psq_far_side.set_delay(300);
    push_seq('{2, 5, 6, 7, 9, 10, 11, 12, 13, 14, 16, 41, 1});
    u_psq_far_side.press(1);
    wait_ph(6'd2);
    repeat (20) @(negedge clk_in);
    u_psq_far_side.set_line(1'b0, 1'b1);
    wait_ph(6'd7);
    repeat (20) @(negedge clk_in);
    check("armed", 16'(trap_armed_out), 16'h0001);
    u_psq_far_side.set_line(1'b1, 1'b1);
    wait_ph(6'd11);
    check("armed", 16'(trap_armed_out), 16'h0000);
    repeat (20) @(negedge clk_in);
    u_psq_far_side.set_line(1'b0, 1'b1);
    wait_ph(6'd13);
    repeat (10) @(negedge clk_in);
    u_psq_far_side.set_line(1'b0, 1'b0);
    wait_idle();
    check("aborts", 16'(u_psq_far_side.abort_cnt), 16'h0002);
    $display("test traps and jumps done");
    // zero pause, implied loop start, other key
    pg[1] = wd(OP_PAUSE, 1'b0, 7'h00);
    pg[2] = wd(OP_PUMP, 1'b0, 7'h00);
    pg[3] = wd(OP_LOOP_FOREVER, 1'b0, 7'h00);
    load();
    u_psq_far_side.set_delay(2);
    // back to phase 1, not on to 4
    push_seq('{2, 3, 1});
    u_psq_far_side.press(0);
    repeat (8) @(negedge clk_in);
    check("buzzer", 16'(buzzer_out), 16'h0001);
    u_psq_far_side.press(0);
    wait_ph(6'd3);
    wait_ph(6'd1);
    repeat (5) @(negedge clk_in);
    u_psq_far_side.press(3);
    repeat (5) @(negedge clk_in);
    check("running", 16'(running_out), 16'h0000);
    check("phases left", 16'(pq.size()), 16'h0000);
    $display("test wait and forever loop done");
    close_out();
  end
endmodule // pump_program_flow_sequencer_tb_top
`default_nettype wire
